// >>> logic/fsps_sequencer.sv
// Flash self-program sequencer: table reads, row holding registers,
// unlock-guarded block erase and row program, each self-timed.
// Assumes the core issues one-cycle strobes on clk_in, and that the
// flash array answers a word read combinationally on flash_rdata_in.
//
// Contract
// RQ1 - A table read copies the addressed program byte into the latch.
// RQ2 - Memory is 16-bit words; pointer bit 0 picks high or low byte.
// RQ3 - Table reads may update the pointer automatically.
// RQ4 - Erase clears one 1024-byte block chosen by pointer bits 21..10.
// RQ5 - No word erase; smallest erase unit is 512 words.
// RQ6 - Self-started erase never covers more than one block.
// RQ7 - Software sets write enable and erase select before erase start.
// RQ8 - Long operations start only after 55h then AAh unlock writes.
// RQ9 - Core is halted during a long cycle, which the timer ends.
// RQ10 - Long write duration is set only by the on-chip timer.
// RQ11 - Stall lasts the erase time or the row write time.
// RQ12 - Programming works on whole 64-byte rows only.
// RQ13 - 64 holding bytes; a table write updates only one of them.
// RQ14 - Control write after loading starts the row long write.
// RQ15 - Holding bytes are kept after programming completes.
// RQ16 - Software programs each byte at most once per erase.
// RQ17 - Software loads the row with pre-increment writes from start-1.
// RQ18 - Software repeats row loads until the whole block is written.
// RQ19 - Pointer must lie in the intended row before start.
// RQ20 - Table write picks holding byte from pointer low six bits.
// RQ21 - Start bit is set-only by software, cleared when timer ends.
// RQ22 - Unlock port has no storage and reads as zero.
// RQ23 - Error flag set on reset-cut or improper timed write.
// RQ24 - Any other write between unlock steps and start abandons it.
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer #(
    parameter int ERASE_CYC = fsps_pkg::ERASE_CYCLES,
    parameter int ROW_WRITE_CYC = fsps_pkg::ROW_WRITE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    // Core side
    input wire logic table_read_op_in,
    input wire logic table_write_op_in,
    input wire logic [1:0] ptr_mode_in,
    input wire logic ptr_load_in,
    input wire logic [fsps_pkg::PTR_W-1:0] ptr_load_data_in,
    input wire logic latch_wr_in,
    input wire logic [7:0] latch_wr_data_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wr_data_in,
    input wire logic unlock_wr_in,
    input wire logic [7:0] unlock_wr_data_in,
    input wire logic other_wr_in,
    output logic [7:0] table_byte_latch_out,
    output logic [fsps_pkg::PTR_W-1:0] program_byte_pointer_out,
    output logic [7:0] flash_control_out,
    output logic [7:0] unlock_port_out,
    output logic core_stall_out,
    // Flash array side
    output logic [fsps_pkg::PTR_W-2:0] flash_word_addr_out,
    input wire logic [fsps_pkg::WORD_W-1:0] flash_rdata_in,
    output logic flash_erase_out,
    output logic [fsps_pkg::PTR_W-1:0] flash_block_base_out,
    output logic flash_program_out,
    output logic [fsps_pkg::PTR_W-1:0] flash_row_base_out,
    output logic [8*fsps_pkg::ROW_BYTES-1:0] flash_row_data_out,
    // Level marking the last reset as a power-on one; low flags a cut timed write
    input wire logic power_on_in
);
    import fsps_pkg::*;

    logic [PTR_W-1:0] ptr_r;
    logic [7:0] latch_r;
    logic [7:0] hold_r [ROW_BYTES];
    logic write_enable_bit_r;
    logic erase_sel_r;
    logic start_r;
    logic err_r;
    logic armed;
    logic timer_busy;
    logic timer_done;
    logic launch;
    logic launch_erase;
    logic [TIMER_W-1:0] launch_count;
    logic erase_run_r;
    logic stall_r;
    logic [PTR_W-1:0] eff_ptr;
    logic [PTR_CNT_W-1:0] ptr_inc;
    logic [PTR_CNT_W-1:0] ptr_dec;
    logic ptr_wr_req;
    logic improper_start;
    logic cut_flag_r;
    // Start-write refusal reasons and accepted table ops
    logic refuse_busy;
    logic refuse_locked;
    logic refuse_no_write_enable_bit;
    logic rd_take;
    logic wr_take;
    logic [ROW_IDX_W-1:0] hold_sel;
    logic [PTR_W-1:0] ptr_step;
    logic [7:0] ctrl_rd;

    // A table op's pointer step touches only the low counted bits
    assign ptr_inc = ptr_r[PTR_CNT_W-1:0] + 1'b1;
    assign ptr_dec = ptr_r[PTR_CNT_W-1:0] - 1'b1;
    assign eff_ptr = (ptr_mode_in == PTR_PRE_INC) ?
        {ptr_r[PTR_W-1], ptr_inc} : ptr_r;
    assign hold_sel = eff_ptr[ROW_IDX_W-1:0]; // RQ20
    // Table ops are dropped while the core is stalled
    assign rd_take = table_read_op_in && !stall_r;
    assign wr_take = table_write_op_in && !stall_r;

    // Pointer after a table op; bit 21 is never stepped
    always_comb begin
        ptr_step = ptr_r;
        unique case (ptr_mode_in)
            PTR_KEEP: ptr_step = ptr_r;
            PTR_POST_INC: ptr_step = {ptr_r[PTR_W-1], ptr_inc}; // RQ3
            PTR_POST_DEC: ptr_step = {ptr_r[PTR_W-1], ptr_dec}; // RQ3
            PTR_PRE_INC: ptr_step = {ptr_r[PTR_W-1], ptr_inc}; // RQ3
        endcase
    end

    assign ptr_wr_req = ctrl_wr_in && ctrl_wr_data_in[CTRL_START_POS];
    // Reasons a start write is refused; a busy start is only dropped
    always_comb begin
        refuse_busy = start_r || timer_busy;
        refuse_locked = !armed; // RQ8 RQ24
        refuse_no_write_enable_bit = !(write_enable_bit_r && ctrl_wr_data_in[CTRL_WRITE_ENABLE_BIT_POS]);
    end
    assign launch = ptr_wr_req && !refuse_busy && !refuse_locked &&
        !refuse_no_write_enable_bit; // RQ8
    // Missing unlock or write enable counts as an improper attempt
    assign improper_start = ptr_wr_req && !refuse_busy && !launch; // RQ23
    assign launch_erase = ctrl_wr_data_in[CTRL_ERASE_POS]; // RQ7
    assign launch_count = launch_erase ? TIMER_W'(ERASE_CYC) :
        TIMER_W'(ROW_WRITE_CYC); // RQ11

    fsps_unlock u_unlock (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .unlock_wr_in(unlock_wr_in),
        .unlock_data_in(unlock_wr_data_in),
        .other_wr_in(other_wr_in || latch_wr_in || ptr_load_in ||
            table_write_op_in || (ctrl_wr_in && !ptr_wr_req)),
        .consume_in(ptr_wr_req),
        .armed_out(armed)
    );

    fsps_timer #(
        .W(TIMER_W)
    ) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .start_in(launch),
        .count_in(launch_count),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );

    // Table pointer: load from core or step on table ops
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_r <= '0;
        end else if (ptr_load_in) begin
            ptr_r <= ptr_load_data_in;
        end else if (rd_take || wr_take) begin
            ptr_r <= ptr_step; // RQ3
        end
    end

    // Word address presented to the array for reads
    assign flash_word_addr_out = eff_ptr[PTR_W-1:1];

    // Latch: core writes it, a table read fills it from the array
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            latch_r <= '0;
        end else if (rd_take) begin
            latch_r <= eff_ptr[0] ? flash_rdata_in[15:8] : flash_rdata_in[7:0]; // RQ1 RQ2
        end else if (latch_wr_in) begin
            latch_r <= latch_wr_data_in;
        end
    end

    // Holding bytes survive programming; no clear on completion
    genvar g;
    generate
        for (g = 0; g < ROW_BYTES; g++) begin : g_hold
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    hold_r[g] <= 8'hFF;
                end else if (wr_take && hold_sel == ROW_IDX_W'(g)) begin // RQ20
                    hold_r[g] <= latch_r; // RQ13 RQ15
                end
            end
            assign flash_row_data_out[8*g +: 8] = hold_r[g];
        end
    endgenerate

    // Control bits: write enable is plain storage; erase select clears when an erase ends
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            write_enable_bit_r <= 1'b0;
            erase_sel_r <= 1'b0;
        end else begin
            if (ctrl_wr_in) begin
                write_enable_bit_r <= ctrl_wr_data_in[CTRL_WRITE_ENABLE_BIT_POS];
            end
            if (timer_done && erase_run_r) begin
                erase_sel_r <= 1'b0;
            end else if (ctrl_wr_in) begin
                erase_sel_r <= ctrl_wr_data_in[CTRL_ERASE_POS];
            end
        end
    end

    // Start bit: software may only set it; timer expiry clears it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_r <= 1'b0;
        end else if (launch) begin
            start_r <= 1'b1; // RQ21
        end else if (timer_done) begin
            start_r <= 1'b0; // RQ21 RQ10
        end
    end

    // Stall and operation kind follow the timer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stall_r <= 1'b0;
            erase_run_r <= 1'b0;
        end else if (launch) begin
            stall_r <= 1'b1; // RQ9
            erase_run_r <= launch_erase;
        end else if (timer_done) begin
            stall_r <= 1'b0; // RQ9 RQ11
            erase_run_r <= 1'b0;
        end
    end

    // One-cycle command pulses to the array, with its addresses
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flash_erase_out <= 1'b0;
            flash_program_out <= 1'b0;
            flash_block_base_out <= '0;
            flash_row_base_out <= '0;
        end else begin
            flash_erase_out <= timer_done && erase_run_r;
            flash_program_out <= timer_done && !erase_run_r; // RQ14 RQ12
            if (launch) begin
                // Single block only; low ten bits ignored
                flash_block_base_out <= {ptr_r[PTR_W-1:BLOCK_LSB],
                    BLOCK_LSB'(0)}; // RQ4 RQ5 RQ6
                flash_row_base_out <= {ptr_r[PTR_W-1:ROW_IDX_W],
                    ROW_IDX_W'(0)}; // RQ12
            end
        end
    end

    // High for the first edge after a reset release; a reset that was not
    // a power-on one is taken as having cut a timed write short
    // Limitation: an idle warm reset raises the error flag as well
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cut_flag_r <= 1'b1;
        end else begin
            cut_flag_r <= 1'b0;
        end
    end

    // Error flag: set at launch, on an improper start or a cut write; cleared by clean completion or a power-on reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            err_r <= 1'b0;
        end else if (cut_flag_r && !power_on_in) begin
            err_r <= 1'b1; // RQ23
        end else if (improper_start || launch) begin
            err_r <= 1'b1; // RQ23
        end else if (timer_done) begin
            err_r <= 1'b0;
        end
    end

    // Control byte as read back; unused bits read as zero
    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[CTRL_START_POS] = start_r; // RQ21
        ctrl_rd[CTRL_WRITE_ENABLE_BIT_POS] = write_enable_bit_r;
        ctrl_rd[CTRL_ERR_POS] = err_r; // RQ23
        ctrl_rd[CTRL_ERASE_POS] = erase_sel_r;
    end

    assign table_byte_latch_out = latch_r;
    assign program_byte_pointer_out = ptr_r;
    assign flash_control_out = ctrl_rd;
    assign unlock_port_out = UNLOCK_READ_VALUE; // RQ22
    // Stall and timer busy move on the same edges; the flop is the output
    assign core_stall_out = stall_r;
endmodule
`default_nettype wire

// >>> logic/fsps_pkg.sv
// Package for the flash self-program sequencer: widths, codes, timing.
// Assumes a 10 MHz core clock; shared by all design files except the timer.
package fsps_pkg;
    localparam int PTR_W = 22;
    localparam int PTR_CNT_W = 21;
    localparam int BLOCK_LSB = 10;
    localparam int ROW_BYTES = 64;
    localparam int ROW_IDX_W = 6;
    localparam int WORD_W = 16;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] UNLOCK_READ_VALUE = 8'h00;
    // Control byte field positions
    localparam int CTRL_START_POS = 1;
    localparam int CTRL_WRITE_ENABLE_BIT_POS = 2;
    localparam int CTRL_ERR_POS = 3;
    localparam int CTRL_ERASE_POS = 4;
    // Table pointer update modes
    localparam logic [1:0] PTR_KEEP = 2'h0;
    localparam logic [1:0] PTR_POST_INC = 2'h1;
    localparam logic [1:0] PTR_POST_DEC = 2'h2;
    localparam logic [1:0] PTR_PRE_INC = 2'h3;
    // Timing, real units then cycles at the core clock
    localparam longint CLK_HZ = 10000000;
    localparam longint ERASE_TIME_US = 2800;
    localparam longint ROW_WRITE_TIME_US = 2800;
    localparam int ERASE_CYCLES = int'((ERASE_TIME_US * CLK_HZ + 999999) / 1000000);
    localparam int ROW_WRITE_CYCLES = int'((ROW_WRITE_TIME_US * CLK_HZ + 999999) / 1000000);
    localparam int TIMER_W = 24;
    typedef enum logic [1:0] {
        FSPS_LOCKED,
        FSPS_GOT_FIRST,
        FSPS_ARMED
    } fsps_unlock_t;
endpackage

// >>> logic/fsps_unlock.sv
// Unlock sequence tracker: 55h then AAh at the unlock port, then start.
// Assumes one-cycle write strobes from the core on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fsps_unlock (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic unlock_wr_in,
    input wire logic [7:0] unlock_data_in,
    input wire logic other_wr_in,
    input wire logic consume_in,
    output logic armed_out
);
    import fsps_pkg::*;
    fsps_unlock_t state_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= FSPS_LOCKED;
        end else if (consume_in || other_wr_in) begin
            state_r <= FSPS_LOCKED; // RQ24
        end else if (unlock_wr_in) begin
            unique case (state_r)
                FSPS_LOCKED: state_r <= (unlock_data_in == UNLOCK_FIRST) ?
                    FSPS_GOT_FIRST : FSPS_LOCKED;
                FSPS_GOT_FIRST: state_r <= (unlock_data_in == UNLOCK_SECOND) ?
                    FSPS_ARMED : (unlock_data_in == UNLOCK_FIRST) ?
                    FSPS_GOT_FIRST : FSPS_LOCKED; // RQ8
                FSPS_ARMED: state_r <= (unlock_data_in == UNLOCK_FIRST) ?
                    FSPS_GOT_FIRST : FSPS_LOCKED;
                default: state_r <= FSPS_LOCKED;
            endcase
        end
    end
    assign armed_out = (state_r == FSPS_ARMED);
endmodule
`default_nettype wire

// >>> logic/fsps_timer.sv
// Programming timer: loads a cycle count, flags the cycle it runs out.
// Assumes start is a one-cycle pulse while idle.
`timescale 1ns/1ps
`default_nettype none
module fsps_timer #(
    parameter int W = 24
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [W-1:0] count_in,
    output logic busy_out,
    output logic done_out
);
    logic [W-1:0] remain_r;
    logic busy_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            remain_r <= '0;
            busy_r <= 1'b0;
        end else if (start_in) begin
            remain_r <= count_in;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            remain_r <= remain_r - 1'b1;
            if (remain_r == {{(W-1){1'b0}}, 1'b1}) begin
                busy_r <= 1'b0;
            end
        end
    end
    assign busy_out = busy_r;
    assign done_out = busy_r && (remain_r == {{(W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// >>> tb/fsps_flash_model.sv
// Program flash array model: answers a word read in the same cycle.
// Assumes the sequencer's word address; contents are a fixed pattern.
`timescale 1ns/1ps
`default_nettype none
module fsps_flash_model (
    input wire logic [20:0] word_addr_in,
    output logic [15:0] rdata_out
);
    // Lanes differ so a swapped byte select shows up
    assign rdata_out = {word_addr_in[7:0] ^ 8'hC3, word_addr_in[15:8] ^ 8'h3C};
endmodule
`default_nettype wire

// >>> tb/fsps_sequencer_chk.sv
// Checker for the flash self-program sequencer, bound to its top ports.
// Assumes one clock, async active-high reset and one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer_chk #(
    parameter int ERASE_CYC = 10,
    parameter int ROW_WRITE_CYC = 10
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic table_read_op_in,
    input wire logic table_write_op_in,
    input wire logic [1:0] ptr_mode_in,
    input wire logic ptr_load_in,
    input wire logic latch_wr_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wr_data_in,
    input wire logic unlock_wr_in,
    input wire logic [7:0] unlock_wr_data_in,
    input wire logic [7:0] table_byte_latch_out,
    input wire logic [fsps_pkg::PTR_W-1:0] program_byte_pointer_out,
    input wire logic [7:0] flash_control_out,
    input wire logic [7:0] unlock_port_out,
    input wire logic core_stall_out,
    input wire logic [fsps_pkg::WORD_W-1:0] flash_rdata_in,
    input wire logic flash_erase_out,
    input wire logic [fsps_pkg::PTR_W-1:0] flash_block_base_out,
    input wire logic flash_program_out,
    input wire logic [fsps_pkg::PTR_W-1:0] flash_row_base_out,
    input wire logic [8*fsps_pkg::ROW_BYTES-1:0] flash_row_data_out
);
    logic [15:0] stall_cnt_r;
    logic erase_op_r;
    logic [7:0] rd_byte;
    assign rd_byte = program_byte_pointer_out[0] ? flash_rdata_in[15:8] : flash_rdata_in[7:0];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stall_cnt_r <= 16'h0000;
        end else begin
            stall_cnt_r <= core_stall_out ? stall_cnt_r + 16'h0001 : 16'h0000;
        end
    end
    // Kind of operation captured on the first stalled cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            erase_op_r <= 1'b0;
        end else if (core_stall_out && stall_cnt_r == 16'h0000) begin
            erase_op_r <= flash_control_out[4];
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    // Write enable already set and no start pending when the unlock begins
    sequence s_unlock_start;
        unlock_wr_in && unlock_wr_data_in == 8'h55 && !core_stall_out &&
            flash_control_out[2:1] == 2'h2
        ##1 unlock_wr_in && unlock_wr_data_in == 8'hAA
        ##1 ctrl_wr_in && ctrl_wr_data_in[2:1] == 2'h3;
    endsequence
    a_unlock_start: assert property (
        s_unlock_start |=> core_stall_out && flash_control_out[3:1] == 3'h7)
        else $error("no stall after unlocked start");
    a_stall_cause: assert property (
        $rose(core_stall_out) |-> $past(ctrl_wr_in && ctrl_wr_data_in[1]))
        else $error("stall without start write");
    a_stall_length: assert property (
        $fell(core_stall_out) |->
            stall_cnt_r == (erase_op_r ? ERASE_CYC : ROW_WRITE_CYC))
        else $error("stall length wrong");
    a_erase_pulse: assert property (
        $fell(core_stall_out) && erase_op_r |-> ##[0:1] flash_erase_out)
        else $error("erase pulse missing");
    a_program_pulse: assert property (
        $fell(core_stall_out) && !erase_op_r |-> ##[0:1] flash_program_out)
        else $error("program pulse missing");
    a_block_base: assert property (
        flash_erase_out |->
            flash_block_base_out == {program_byte_pointer_out[21:10], 10'h000})
        else $error("erase block base wrong");
    a_row_base: assert property (
        flash_program_out |->
            flash_row_base_out == {program_byte_pointer_out[21:6], 6'h00})
        else $error("row base wrong");
    a_start_held: assert property ($fell(flash_control_out[1]) |-> $past(core_stall_out))
        else $error("start cleared outside timed cycle");
    a_unlock_zero: assert property (unlock_port_out == 8'h00)
        else $error("unlock port not zero");
    a_read_latch: assert property (
        table_read_op_in && ptr_mode_in != 2'h3 && !core_stall_out && !latch_wr_in |=>
            table_byte_latch_out == $past(rd_byte))
        else $error("table read byte wrong");
    a_hold_write: assert property (
        table_write_op_in && ptr_mode_in == 2'h3 && !core_stall_out && !ptr_load_in |=>
            flash_row_data_out[8*program_byte_pointer_out[5:0] +: 8] ==
            $past(table_byte_latch_out))
        else $error("holding byte wrong");
endmodule
bind fsps_sequencer fsps_sequencer_chk #(
    .ERASE_CYC(ERASE_CYC),
    .ROW_WRITE_CYC(ROW_WRITE_CYC)
) fsps_sequencer_chk_i (.*);
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the flash self-program sequencer.
// Assumes short timer parameters; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int N = 10;
    localparam int M = 14;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic rd = 1'b0, wt = 1'b0, pl = 1'b0, lw = 1'b0, cw = 1'b0, uw = 1'b0, ow = 1'b0, pon = 1'b1;
    logic [1:0] pm = 2'h0;
    logic [21:0] pd = 22'h000000;
    logic [7:0] lat_d = 8'h00, cd = 8'h00, ud = 8'h00;
    logic [7:0] lat, ctl, unl;
    logic [21:0] ptr, bb, rb, p, a;
    logic [20:0] wa;
    logic [15:0] rdat;
    logic stall, er, pg, se, sp;
    logic [511:0] row, exp_row;
    int n_fail = 0;
    int tests_run = 0;
    int n;
    fsps_flash_model fsps_flash_model_i (.word_addr_in(wa), .rdata_out(rdat));
    fsps_sequencer #(.ERASE_CYC(N), .ROW_WRITE_CYC(M)) fsps_sequencer_i (
        .clk_in(clk_in), .rst_in(rst_in), .table_read_op_in(rd), .table_write_op_in(wt),
        .ptr_mode_in(pm), .ptr_load_in(pl), .ptr_load_data_in(pd), .latch_wr_in(lw),
        .latch_wr_data_in(lat_d), .ctrl_wr_in(cw), .ctrl_wr_data_in(cd), .unlock_wr_in(uw),
        .unlock_wr_data_in(ud), .other_wr_in(ow), .table_byte_latch_out(lat),
        .program_byte_pointer_out(ptr), .flash_control_out(ctl), .unlock_port_out(unl),
        .core_stall_out(stall), .flash_word_addr_out(wa), .flash_rdata_in(rdat),
        .flash_erase_out(er), .flash_block_base_out(bb), .flash_program_out(pg),
        .flash_row_base_out(rb), .flash_row_data_out(row), .power_on_in(pon));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    function automatic logic [7:0] exp_byte(input logic [21:0] x);
        return x[0] ? (x[8:1] ^ 8'hC3) : (x[16:9] ^ 8'h3C);
    endfunction
    // Pointer arithmetic never reaches bit 21
    function automatic logic [21:0] step(input logic [21:0] x, input logic [1:0] m);
        case (m)
            2'h0: return x;
            2'h2: return {x[21], x[20:0] - 21'h000001};
            default: return {x[21], x[20:0] + 21'h000001};
        endcase
    endfunction
    task automatic chk(input string s, input logic [511:0] e, input logic [511:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %0h got %0h", s, e, g);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic ld(input logic [21:0] x);
        @(negedge clk_in);
        pl = 1'b1;
        pd = x;
        @(negedge clk_in);
        pl = 1'b0;
    endtask
    task automatic tbl(input logic w, input logic [1:0] m);
        @(negedge clk_in);
        rd = !w;
        wt = w;
        pm = m;
        @(negedge clk_in);
        rd = 1'b0;
        wt = 1'b0;
    endtask
    task automatic op(input logic [7:0] u1, input logic [7:0] u2, input logic [7:0] c,
                      input logic o, input logic go, input logic cut);
        // Enable bits go in first, as software must do before unlocking
        @(negedge clk_in);
        cw = 1'b1;
        cd = c & 8'hFD;
        @(negedge clk_in);
        cw = 1'b0;
        uw = 1'b1;
        ud = u1;
        @(negedge clk_in);
        ud = u2;
        @(negedge clk_in);
        uw = 1'b0;
        if (o) begin
            ow = 1'b1;
            @(negedge clk_in);
            ow = 1'b0;
        end
        cw = 1'b1;
        cd = c;
        @(negedge clk_in);
        cw = 1'b0;
        if (cut) begin
            repeat (3) @(negedge clk_in);
            pon = 1'b0;
            rst_in = 1'b1;
            @(negedge clk_in);
            rst_in = 1'b0;
            @(negedge clk_in);
            chk("cut", 2'h2, {ctl[3], stall});
            pon = 1'b1;
        end else begin
            // Stall is already up on this edge and must be counted
            n = stall ? 1 : 0;
            se = 1'b0;
            sp = 1'b0;
            repeat (40) begin
                @(negedge clk_in);
                if (stall) n++;
                if (er) se = 1'b1;
                if (pg) sp = 1'b1;
            end
            chk("stall", go ? (c[4] ? N : M) : 0, n);
            chk("erase", go & c[4], se);
            chk("prog", go & ~c[4], sp);
            chk("flags", {~go, c[2], 1'b0}, ctl[3:1]);
        end
    endtask
    initial begin
        void'($urandom(54));
        repeat (12) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        chk("ctl0", 8'h00, ctl);
        chk("hold0", {512{1'b1}}, row);
        chk("unl", 8'h00, unl);
        for (int i = 0; i < 16; i++) begin
            p = 22'($urandom);
            if (i < 3) p = (i == 1) ? 22'h1FFFFF : 22'h200000;
            ld(p);
            tbl(1'b0, 2'(i));
            a = (i % 4 == 3) ? step(p, 2'h3) : p;
            chk("latch", exp_byte(a), lat);
            chk("ptr", step(p, 2'(i)), ptr);
        end
        p = 22'($urandom);
        ld(p);
        op(8'h55, 8'hAA, 8'h16, 1'b0, 1'b1, 1'b0);
        chk("blk", {p[21:10], 10'h000}, bb);
        // Row inside the block just erased, each byte programmed once
        p = {p[21:10], 4'($urandom) | 4'h1, 6'h00};
        ld(p - 22'h000001);
        for (int g = 0; g < 64; g++) begin
            lat_d = 8'($urandom);
            exp_row[8*g +: 8] = lat_d;
            @(negedge clk_in);
            lw = 1'b1;
            @(negedge clk_in);
            lw = 1'b0;
            tbl(1'b1, 2'h3);
        end
        chk("row", exp_row, row);
        op(8'h55, 8'hAA, 8'h06, 1'b0, 1'b1, 1'b0);
        chk("rowb", p, rb);
        chk("keep", exp_row, row);
        op(8'h55, 8'hAA, 8'h12, 1'b0, 1'b0, 1'b0);
        op(8'hAA, 8'h55, 8'h06, 1'b0, 1'b0, 1'b0);
        op(8'h55, 8'hAA, 8'h06, 1'b1, 1'b0, 1'b0);
        op(8'h55, 8'hAA, 8'h06, 1'b0, 1'b1, 1'b0);
        op(8'h55, 8'hAA, 8'h06, 1'b0, 1'b1, 1'b1);
        conclude();
    end
    initial begin
        #2000000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
